// *** verilog/rxm_map.svh ***
`ifndef RXM_MAP_SVH
`define RXM_MAP_SVH

// Register byte offsets
`define RXM_ADDR_CTRL        8'h00
`define RXM_ADDR_STATE       8'h04
`define RXM_ADDR_INT_STATUS  8'h08
`define RXM_ADDR_INT_MASK    8'h0C

// Control register fields
`define RXM_CTRL_SINGLE_RAIL 0
`define RXM_CTRL_MON_LO      1
`define RXM_CTRL_MON_HI      2
`define RXM_CTRL_RATE_LO     3
`define RXM_CTRL_RATE_HI     4
`define RXM_CTRL_WIDTH       5
`define RXM_CTRL_RESET       5'h00

// State register fields
`define RXM_ST_HOST          0
`define RXM_ST_SINGLE_RAIL   1
`define RXM_ST_MONITOR       2
`define RXM_ST_RATE_LO       3
`define RXM_ST_RATE_HI       4
`define RXM_ST_SFM           5
`define RXM_ST_REF_ACTIVE    6
`define RXM_ST_WIDTH         7

// Interrupt fields
`define RXM_INT_LCV          0
`define RXM_INT_RAIL_CHANGE  1
`define RXM_INT_REF_LOST     2
`define RXM_INT_WIDTH        3
`define RXM_INT_RESET        3'h0

// Timing
`define RXM_CLK_PERIOD_NS    10
`define RXM_SYS_CLK_KHZ      100000
`define RXM_REF_TIMEOUT_NS   2000
`define RXM_E3_KHZ           34368
`define RXM_DS3_KHZ          44736
`define RXM_STS1_KHZ         51840
`define RXM_SYNTH_DIV        4

`endif

// *** verilog/rxm_pkg.sv ***
package rxm_pkg;

  typedef enum logic [1:0] {
    RXM_RATE_DS3  = 2'b00,
    RXM_RATE_STS1 = 2'b01,
    RXM_RATE_E3   = 2'b10
  } rxm_rate_type;

endpackage

// *** verilog/rxm_synth_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface rxm_synth_if;
  import rxm_pkg::*;

  logic         enable;
  rxm_rate_type rate;
  logic         clk_out;

  modport ctrl  (output enable, output rate, input clk_out);
  modport synth (input enable, input rate, output clk_out);
endinterface

`default_nettype wire

// *** verilog/rxm_clk_synth.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rxm_map.svh"

module rxm_clk_synth #(
  parameter int ACC_W = 24
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // Control from the mode logic
  rxm_synth_if.synth sif
);
  import rxm_pkg::*;

  localparam logic [63:0] SCALE   = 64'(`RXM_SYS_CLK_KHZ) * 64'(`RXM_SYNTH_DIV);
  localparam logic [63:0] INC_E3  = (64'(`RXM_E3_KHZ) << ACC_W) / SCALE;
  localparam logic [63:0] INC_DS3 = (64'(`RXM_DS3_KHZ) << ACC_W) / SCALE;
  localparam logic [63:0] INC_STS = (64'(`RXM_STS1_KHZ) << ACC_W) / SCALE;

  logic [ACC_W-1:0] phase;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] next_phase;

  // Phase step per line rate
  assign step = (sif.rate == RXM_RATE_E3)   ? INC_E3[ACC_W-1:0]  :
                (sif.rate == RXM_RATE_STS1) ? INC_STS[ACC_W-1:0] :
                                              INC_DS3[ACC_W-1:0];

  assign next_phase = sif.enable ? phase + step : '0;

  // Accumulator, top bit is the clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase       <= '0;
      sif.clk_out <= 1'b0;
    end else begin
      phase       <= next_phase;
      sif.clk_out <= sif.enable & next_phase[ACC_W-1];
    end
  end

endmodule

`default_nettype wire

// *** verilog/rxm_rx_mode_select.sv ***
// Summary of operation
// - Dual rail: negative pulses appear on output
// - Host mode: rail choice from control bit
// - Single rail: output flags code violations only
// - Monitor pin high enters monitoring mode
// - Host mode: monitoring from control bits
// - Host mode: monitor pin drives serial data
// - Synthesizer derives line clock from system clock; clock_out runs at a quarter of the line rate
// - Single-frequency mode drives synthesized clock out
// - Single rail enables codec, dual disables
// - Hardware rate pins pick E3, STS-1, DS3
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rxm_map.svh"

module rxm_rx_mode_select (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  // Mode pins
  input  wire logic         control_mode_select,
  input  wire logic         rail_mode_select,
  input  wire logic         e3_select,
  input  wire logic         sts1_select,
  input  wire logic         single_freq_enable,
  input  wire logic         reference_clock_in,
  // Receiver events
  input  wire logic         rx_pos_pulse,
  input  wire logic         rx_neg_pulse,
  input  wire logic         lcv_detect,
  // Serial interface data
  input  wire logic         sdo_data,
  input  wire logic         sdo_drive,
  // Monitor pin, two-way
  input  wire logic         monitor_mode_select,
  output logic              serial_data_out,
  output logic              serial_data_out_oe,
  // Receive outputs
  output logic              receive_positive_rail_out,
  output logic              receive_negative_rail_out,
  // Mode outputs
  output logic              codec_enable,
  output logic              monitor_mode_active,
  output var rxm_pkg::rxm_rate_type line_rate,
  output logic              clock_out,
  // Interrupt
  output logic              irq
);
  import rxm_pkg::*;

  localparam int          REF_CYC_INT = `RXM_REF_TIMEOUT_NS / `RXM_CLK_PERIOD_NS;
  localparam logic [7:0]  REF_CYC     = 8'(REF_CYC_INT);

  logic [`RXM_CTRL_WIDTH-1:0] ctrl;
  logic [`RXM_INT_WIDTH-1:0]  int_status;
  logic [`RXM_INT_WIDTH-1:0]  int_mask;
  logic                       ref_prev;
  logic [7:0]                 ref_count;
  logic                       ref_active_q;

  wire                        host_mode;
  wire                        single_rail_eff;
  wire                        monitor_eff;
  rxm_rate_type               hw_rate;
  rxm_rate_type               host_rate;
  rxm_rate_type               rate_eff;
  wire                        ref_edge;
  wire                        ref_active;
  wire                        sel_ctrl;
  wire                        sel_state;
  wire                        sel_int;
  wire                        sel_mask;
  wire [`RXM_ST_WIDTH-1:0]    state_word;
  wire [`RXM_INT_WIDTH-1:0]   events;
  wire [`RXM_INT_WIDTH-1:0]   clr_bits;
  wire [`RXM_INT_WIDTH-1:0]   next_int_status;
  wire [7:0]                  next_ref_count;
  wire [31:0]                 next_rdata;
  wire                        next_neg_out;

  rxm_synth_if sif ();

  // Effective configuration
  assign host_mode       = control_mode_select;
  assign single_rail_eff = host_mode ? ctrl[`RXM_CTRL_SINGLE_RAIL]
                                     : rail_mode_select;
  assign monitor_eff     = host_mode ? (ctrl[`RXM_CTRL_MON_HI:`RXM_CTRL_MON_LO] != 2'h0)
                                     : monitor_mode_select;
  assign hw_rate         = e3_select   ? RXM_RATE_E3   :
                           sts1_select ? RXM_RATE_STS1 :
                                         RXM_RATE_DS3;
  assign host_rate       = (ctrl[`RXM_CTRL_RATE_HI:`RXM_CTRL_RATE_LO] == 2'h2) ? RXM_RATE_E3   :
                           (ctrl[`RXM_CTRL_RATE_HI:`RXM_CTRL_RATE_LO] == 2'h1) ? RXM_RATE_STS1 :
                                                                                 RXM_RATE_DS3;
  assign rate_eff        = host_mode ? host_rate : hw_rate;

  // Negative rail or violation flag
  assign next_neg_out = single_rail_eff ? lcv_detect
                                        : rx_neg_pulse;

  // Synthesizer control
  assign sif.enable = single_freq_enable;
  assign sif.rate   = rate_eff;

  // Reference activity
  assign ref_edge       = reference_clock_in & ~ref_prev;
  assign ref_active     = (ref_count < REF_CYC);
  assign next_ref_count = ref_edge ? 8'h00 :
                          (ref_count == 8'hFF) ? 8'hFF : ref_count + 8'h01;

  // Address decode
  assign sel_ctrl  = (reg_addr == `RXM_ADDR_CTRL);
  assign sel_state = (reg_addr == `RXM_ADDR_STATE);
  assign sel_int   = (reg_addr == `RXM_ADDR_INT_STATUS);
  assign sel_mask  = (reg_addr == `RXM_ADDR_INT_MASK);

  assign state_word = {ref_active_q, single_freq_enable, line_rate,
                       monitor_mode_active, codec_enable, host_mode};

  assign next_rdata = !reg_rd   ? 32'h0000_0000 :
                      sel_ctrl  ? {{(32-`RXM_CTRL_WIDTH){1'b0}}, ctrl} :
                      sel_state ? {{(32-`RXM_ST_WIDTH){1'b0}}, state_word} :
                      sel_int   ? {{(32-`RXM_INT_WIDTH){1'b0}}, int_status} :
                      sel_mask  ? {{(32-`RXM_INT_WIDTH){1'b0}}, int_mask} :
                                  32'h0000_0000;

  // Sticky events, set wins over clear
  assign events[`RXM_INT_LCV]         = single_rail_eff & lcv_detect;
  assign events[`RXM_INT_RAIL_CHANGE] = single_rail_eff ^ codec_enable;
  assign events[`RXM_INT_REF_LOST]    = ref_active_q & ~ref_active;
  assign clr_bits        = (reg_wr && sel_int) ? reg_wdata[`RXM_INT_WIDTH-1:0]
                                               : {`RXM_INT_WIDTH{1'b0}};
  assign next_int_status = (int_status & ~clr_bits) | events;

  // Control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl     <= `RXM_CTRL_RESET;
      int_mask <= `RXM_INT_RESET;
    end else begin
      if (reg_wr && sel_ctrl) begin
        ctrl <= reg_wdata[`RXM_CTRL_WIDTH-1:0];
      end
      if (reg_wr && sel_mask) begin
        int_mask <= reg_wdata[`RXM_INT_WIDTH-1:0];
      end
    end
  end

  // Interrupt and read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      int_status <= `RXM_INT_RESET;
      irq        <= 1'b0;
      reg_rdata  <= 32'h0000_0000;
    end else begin
      int_status <= next_int_status;
      irq        <= |(int_status & int_mask);
      reg_rdata  <= next_rdata;
    end
  end

  // Reference watch
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ref_prev     <= 1'b0;
      ref_count    <= 8'hFF;
      ref_active_q <= 1'b0;
    end else begin
      ref_prev     <= reference_clock_in;
      ref_count    <= next_ref_count;
      ref_active_q <= ref_active;
    end
  end

  // Receive outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      receive_positive_rail_out <= 1'b0;
      receive_negative_rail_out <= 1'b0;
    end else begin
      receive_positive_rail_out <= rx_pos_pulse;
      receive_negative_rail_out <= next_neg_out;
    end
  end

  // Mode outputs and monitor pin
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      codec_enable        <= 1'b0;
      monitor_mode_active <= 1'b0;
      line_rate           <= RXM_RATE_DS3;
      serial_data_out     <= 1'b0;
      serial_data_out_oe  <= 1'b0;
    end else begin
      codec_enable        <= single_rail_eff;
      monitor_mode_active <= monitor_eff;
      line_rate           <= rate_eff;
      serial_data_out     <= host_mode & sdo_data;
      serial_data_out_oe  <= host_mode & sdo_drive;
    end
  end

  rxm_clk_synth #(
    .ACC_W (24)
  ) u_synth (
    .clock (clock),
    .rst_n (rst_n),
    .sif   (sif.synth)
  );

  assign clock_out = sif.clk_out;

endmodule

`default_nettype wire

// *** dv/rxm_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module rxm_checker (
  // Clock, reset, strobe
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  // Pins
  input wire logic control_mode_select,
  input wire logic rail_mode_select,
  input wire logic e3_select,
  input wire logic sts1_select,
  input wire logic single_freq_enable,
  input wire logic monitor_mode_select,
  input wire logic rx_pos_pulse,
  input wire logic rx_neg_pulse,
  input wire logic lcv_detect,
  input wire logic sdo_data,
  input wire logic sdo_drive,
  // Outputs
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic receive_positive_rail_out,
  input wire logic receive_negative_rail_out,
  input wire logic codec_enable,
  input wire logic monitor_mode_active,
  input wire rxm_pkg::rxm_rate_type line_rate,
  input wire logic clock_out
);
  import rxm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_dual; $past(rst_n) && !codec_enable |->
    receive_negative_rail_out == $past(rx_neg_pulse); endproperty
  a_dual: assert property (p_dual) else $error("dual rail output");
  property p_pos; $past(rst_n) |->
    receive_positive_rail_out == $past(rx_pos_pulse); endproperty
  a_pos: assert property (p_pos) else $error("positive rail output");
  property p_lcv; $past(rst_n) && codec_enable |->
    receive_negative_rail_out == $past(lcv_detect); endproperty
  a_lcv: assert property (p_lcv) else $error("violation flag");
  property p_hwrail; $past(rst_n) && !$past(control_mode_select) |->
    codec_enable == $past(rail_mode_select); endproperty
  a_hwrail: assert property (p_hwrail) else $error("hw rail");
  property p_hwmon; $past(rst_n) && !$past(control_mode_select) |->
    monitor_mode_active == $past(monitor_mode_select); endproperty
  a_hwmon: assert property (p_hwmon) else $error("hw monitor");
  property p_hwrate; $past(rst_n) && !$past(control_mode_select) |-> line_rate ==
    ($past(e3_select) ? RXM_RATE_E3 : $past(sts1_select) ? RXM_RATE_STS1 : RXM_RATE_DS3);
  endproperty
  a_hwrate: assert property (p_hwrate) else $error("hw rate");
  property p_host; $past(rst_n, 2) && $past(control_mode_select, 2) && $past(control_mode_select)
    && !$past(reg_wr, 2) && !$past(reg_wr) |->
    $stable({codec_enable, monitor_mode_active, line_rate}); endproperty
  a_host: assert property (p_host) else $error("host mode pins");
  property p_sdo; $past(rst_n) |-> {serial_data_out_oe, serial_data_out} ==
    $past({control_mode_select & sdo_drive, control_mode_select & sdo_data}); endproperty
  a_sdo: assert property (p_sdo) else $error("serial out");
  property p_clkoff; !single_freq_enable [*3] |-> !clock_out; endproperty
  a_clkoff: assert property (p_clkoff) else $error("clock out idle");
  property p_clkrun; single_freq_enable [*8] |-> ##[1:8] $changed(clock_out); endproperty
  a_clkrun: assert property (p_clkrun) else $error("clock out stuck");
endmodule
`default_nettype wire

// *** dv/rxm_framer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rxm_framer_model (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // Device receive output
  input  wire logic   neg_rail,
  // Pulses seen
  output logic [15:0] neg_count
);
  // Sampled on the receive clock only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      neg_count <= 16'h0000;
    end else if (neg_rail) begin
      neg_count <= neg_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** dv/rxm_rx_mode_select_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rxm_map.svh"
module rxm_rx_mode_select_tb;
  import rxm_pkg::*;
  logic clock, rst_n, reg_wr, reg_rd, control_mode_select, rail_mode_select, e3_select;
  logic sts1_select, single_freq_enable, reference_clock_in, rx_pos_pulse, rx_neg_pulse;
  logic lcv_detect, sdo_data, sdo_drive, mon_drv, serial_data_out, serial_data_out_oe;
  logic receive_positive_rail_out, receive_negative_rail_out, codec_enable;
  logic monitor_mode_active, clock_out, irq, lastc;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, seed, c;
  logic [15:0] exp_count, neg_count;
  logic [3:0] pe;
  rxm_rate_type line_rate;
  int err_total, comparisons, cyc, n, e;
  wire monitor_mode_select = serial_data_out_oe ? serial_data_out : mon_drv;
  rxm_rx_mode_select dut (.*);
  rxm_framer_model far (.clock(clock), .rst_n(rst_n), .neg_rail(receive_negative_rail_out),
    .neg_count(neg_count));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic rxm_rate_type exp_rate(input logic e3, input logic s1);
    return e3 ? RXM_RATE_E3 : (s1 ? RXM_RATE_STS1 : RXM_RATE_DS3);
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    comparisons++;
    if (s !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    reference_clock_in <= ~reference_clock_in;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {seed, err_total, comparisons, cyc, exp_count, pe} = {32'h00003467, 96'h0, 20'h0};
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, mon_drv, reference_clock_in} = '0;
    {control_mode_select, rail_mode_select, e3_select, sts1_select} = 4'h0;
    {single_freq_enable, rx_pos_pulse, rx_neg_pulse, lcv_detect, sdo_data, sdo_drive} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (300) begin
      @(posedge clock);
      rv = rnd();
      {rail_mode_select, e3_select, sts1_select, mon_drv} <= rv[3:0];
      {rx_pos_pulse, rx_neg_pulse, lcv_detect, sdo_data, sdo_drive} <= rv[8:4];
      exp_count += 16'(rv[3] ? rv[6] : rv[7]);
      @(negedge clock);
      chk("hw_mode", pe, {line_rate, codec_enable, monitor_mode_active});
      pe = {exp_rate(rv[2], rv[1]), rv[3], rv[0]};
    end
    @(posedge clock);
    {rx_pos_pulse, rx_neg_pulse, lcv_detect, sdo_data, sdo_drive} <= '0;
    control_mode_select <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("neg_count", exp_count, neg_count);
    foreach (pe[i]) begin
      c = (i == 0) ? 32'h13 : (i == 1) ? 32'h08 : (i == 2) ? 32'h04 : 32'h13;
      wr(`RXM_ADDR_CTRL, c);
      {rail_mode_select, sdo_data, sdo_drive} <= {~c[0], c[0], 1'b1};
      rd(`RXM_ADDR_STATE);
      chk("state", {exp_rate(c[4] & ~c[3], c[3] & ~c[4]), |c[2:1], c[0], 1'b1},
          rv & 32'h1F);
      chk("sdo", {1'b1, c[0], c[0]},
          {serial_data_out_oe, serial_data_out, monitor_mode_select});
    end
    rd(8'h10);
    chk("unmapped", 0, rv);
    wr(`RXM_ADDR_INT_STATUS, 32'h7);
    wr(`RXM_ADDR_INT_MASK, 32'h1);
    @(negedge clock) chk("irq", 0, irq);
    @(posedge clock) lcv_detect <= 1'b1;
    @(posedge clock) lcv_detect <= 1'b0;
    repeat (2) @(negedge clock);
    chk("irq", 1, irq);
    wr(`RXM_ADDR_INT_STATUS, 32'h1);
    repeat (2) @(negedge clock);
    chk("irq", 0, irq);
    @(posedge clock) single_freq_enable <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(`RXM_ADDR_CTRL, (k == 0) ? 32'h10 : (k == 1) ? 32'h00 : 32'h08);
      e = ((k == 0) ? `RXM_E3_KHZ : (k == 1) ? `RXM_DS3_KHZ : `RXM_STS1_KHZ) * 4 / 1000;
      e = e / `RXM_SYNTH_DIV;
      repeat (4) @(negedge clock);
      {n, lastc} = {32'h0, clock_out};
      repeat (400) begin
        @(negedge clock);
        n += int'(clock_out & ~lastc);
        lastc = clock_out;
      end
      chk("clk_edges", 1, (n >= e - 1 && n <= e + 1));
    end
    @(posedge clock) single_freq_enable <= 1'b0;
    repeat (4) @(negedge clock);
    chk("clock_out", 0, clock_out);
    wrap_up();
  end
endmodule
bind rxm_rx_mode_select rxm_checker chk_i (.*);
`default_nettype wire
